// >>> design/vmem_pkg.sv
/*
 * Package for the vertical mesh event monitor: register map, control field
 * layout, event codes, sizes, ring indices and carrier structs.
 * Assumes one mesh clock and a classic Wishbone slave port with 32-bit data.
 */
package vmem_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses)
	localparam logic [7:0] VMEM_CTL_OFS     = 8'h00;
	localparam logic [7:0] VMEM_CNT_LO_OFS  = 8'h04;
	localparam logic [7:0] VMEM_CNT_HI_OFS  = 8'h08;
	localparam logic [7:0] VMEM_STAT_OFS    = 8'h0C;

	// Control field layout
	localparam int VMEM_EVSEL_LSB  = 0;
	localparam int VMEM_UMASK_LSB  = 8;
	localparam int VMEM_EN_BIT     = 22;
	localparam int VMEM_RST_BIT    = 17;
	localparam int VMEM_SIDE_BIT   = 23;
	localparam logic [31:0] VMEM_CTL_RESET = 32'h0000_0000;
	localparam logic [31:0] VMEM_CTL_WMASK = 32'h00C0_FFFF;

	// Event codes
	localparam logic [7:0] VMEM_EV_OCC_MAIN  = 8'h90;
	localparam logic [7:0] VMEM_EV_OCC_CRED  = 8'h91;
	localparam logic [7:0] VMEM_EV_STV_MAIN  = 8'h9A;
	localparam logic [7:0] VMEM_EV_STV_CRED  = 8'h9B;
	localparam logic [7:0] VMEM_EV_REQ_BUSY  = 8'hB0;
	localparam logic [7:0] VMEM_EV_ACK_BUSY  = 8'hB1;
	localparam logic [7:0] VMEM_EV_BLK_BUSY  = 8'hB2;
	localparam logic [7:0] VMEM_EV_AKC_BUSY  = 8'hB4;

	// Class, lane and ring counts, fill and counter widths
	localparam int VMEM_NMAIN = 7;
	localparam int VMEM_NCRED = 3;
	localparam int VMEM_NLANE = 4;
	localparam int VMEM_NRING = 4;
	localparam int VMEM_FILLW = 6;
	localparam int VMEM_CNTW  = 48;

	// Ring indices
	localparam int VMEM_RING_REQ = 0;
	localparam int VMEM_RING_ACK = 1;
	localparam int VMEM_RING_BLK = 2;
	localparam int VMEM_RING_AKC = 3;

	////////////////////////////////////////////////////////////////////////
	// Per-cycle observation of one physical ring lane at this stop
	typedef struct packed {
		logic cw_even;
		logic cw_odd;
		logic ccw_even;
		logic ccw_odd;
	} vmem_phys_t;

	// Per-ring activity: slot occupied and whether this stop injected it
	typedef struct packed {
		vmem_phys_t valid;
		vmem_phys_t sent_here;
	} vmem_ring_t;

	typedef enum logic [1:0] {
		vmem_kind_none,
		vmem_kind_fill,
		vmem_kind_pulse
	} vmem_kind_t;

endpackage : vmem_pkg

// >>> design/vmem_ring_lane.sv
/*
 * One vertical ring's busy detector: turns physical clockwise and
 * counter-clockwise lane activity into up/down even/odd busy bits.
 * Assumes inputs synchronous to the mesh clock.
 */
`timescale 1ns/1ps
module vmem_ring_lane
	import vmem_pkg::*;
(
	// Ring observation
	input  wire vmem_ring_t      ring,
	input  wire logic            left_side,
	// Direction view: up-even, up-odd, down-even, down-odd
	output logic [VMEM_NLANE-1:0] busy
);

	vmem_phys_t use_v;

	// Passing or sinking counts, own injection does not
	assign use_v = ring.valid & ~ring.sent_here;

	// Left side: up is clockwise; right side swaps
	assign busy = left_side ?
		{use_v.ccw_odd, use_v.ccw_even, use_v.cw_odd, use_v.cw_even} :
		{use_v.cw_odd, use_v.cw_even, use_v.ccw_odd, use_v.ccw_even};

endmodule : vmem_ring_lane

// >>> design/vmem_monitor.sv
/*
 * Vertical mesh event monitor: event select, unit-mask qualify and a
 * 48-bit counter, reached over a classic Wishbone slave.
 * Assumes all inputs synchronous to core_clk; stop_index is static.
 */
// The Wishbone interface to the registers and the register offsets were decided locally.
// Contract
// - Code 0x90 sums main egress fill of seven agent/class mask bits.
// - Code 0x91 sums ack-credit egress fill for agent zero, agent one.
// - Code 0x9A counts starvation over the same seven mask bits.
// - Code 0x9B counts credit starvation: agent zero, agent one, ring credit.
// - Ring busy counts passing or sunk packets, never own injection.
// - Codes 0xB0-0xB2 count request, ack, blockdata ring lanes by mask.
// - Code 0xB4 counts ack-credit ring lanes with same four mask bits.
// - Left side: up is clockwise; right side reversed; first half left.
`timescale 1ns/1ps
module vmem_monitor
	import vmem_pkg::*;
#(
	parameter int NUM_AGENTS = 8,
	parameter int STOP_W     = 4
)(
	// Clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     nrst,
	input  wire logic                     clk_en,
	// Wishbone slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [7:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	// Stop position
	input  wire logic [STOP_W-1:0]        stop_index,
	// Egress fill levels and starvation flags
	input  wire logic [VMEM_NMAIN*VMEM_FILLW-1:0] fill_main,
	input  wire logic [2*VMEM_FILLW-1:0]          fill_credit,
	input  wire logic [VMEM_NMAIN-1:0]            starve_main,
	input  wire logic [VMEM_NCRED-1:0]            starve_credit,
	// Ring activity
	input  wire vmem_ring_t [VMEM_NRING-1:0]      rings,
	// Counter view
	output logic [VMEM_CNTW-1:0]          count_q
);

	////////////////////////////////////////////////////////////////////////
	// Control register
	logic [31:0]            ctl_q;
	logic                   wb_req;
	logic                   ack_q;
	logic [31:0]            rdat_q;
	logic                   left_q;
	logic [7:0]             evsel;
	logic [7:0]             umask;
	logic [VMEM_CNTW-1:0]   inc;
	vmem_kind_t             kind;
	logic [VMEM_NLANE-1:0]  busy [VMEM_NRING];
	logic                   cnt_wr_lo;
	logic                   cnt_wr_hi;
	logic                   ctl_wr;
	logic [VMEM_CNTW-1:0]   fill_main_sel [VMEM_NMAIN];
	logic [VMEM_CNTW-1:0]   fill_cred_sel [2];
	logic [VMEM_CNTW-1:0]   fill_main_sum;
	logic [VMEM_CNTW-1:0]   fill_cred_sum;
	logic                   starve_main_hit;
	logic                   starve_cred_hit;
	logic [VMEM_NRING-1:0]  ring_hit;

	// Masking with ack_q keeps a held request from being taken twice
	assign wb_req    = wb_cyc_i & wb_stb_i & ~ack_q;
	assign ctl_wr    = wb_req & wb_we_i & (wb_adr_i == VMEM_CTL_OFS);
	assign cnt_wr_lo = wb_req & wb_we_i & (wb_adr_i == VMEM_CNT_LO_OFS);
	assign cnt_wr_hi = wb_req & wb_we_i & (wb_adr_i == VMEM_CNT_HI_OFS);
	assign evsel     = ctl_q[VMEM_EVSEL_LSB +: 8];
	assign umask     = ctl_q[VMEM_UMASK_LSB +: 8];
	assign wb_ack_o  = ack_q;
	assign wb_dat_o  = rdat_q;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctl_q <= VMEM_CTL_RESET;
		end else if (clk_en && ctl_wr) begin
			// Reset bit is masked out here, so it clears the counter once only
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					ctl_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8] & VMEM_CTL_WMASK[b*8 +: 8];
				end
			end
		end
	end

	// Side of the ring, taken from stop_index on every enabled cycle
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			left_q <= 1'b1;
		end else if (clk_en) begin
			left_q <= 32'(stop_index) < (NUM_AGENTS / 2);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus answer: one wait-free cycle after the request
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_q <= wb_req;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					VMEM_CTL_OFS:    rdat_q <= ctl_q;
					VMEM_CNT_LO_OFS: rdat_q <= count_q[31:0];
					VMEM_CNT_HI_OFS: rdat_q <= {16'h0000, count_q[VMEM_CNTW-1:32]};
					VMEM_STAT_OFS:   rdat_q <= {30'h0000_0000, left_q, ctl_q[VMEM_EN_BIT]};
					default:         rdat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Ring lane views
	for (genvar r = 0; r < VMEM_NRING; r++) begin : g_ring
		vmem_ring_lane u_lane (
			.ring      (rings[r]),
			.left_side (left_q),
			.busy      (busy[r])
		);
		// One event per cycle, however many masked lanes are busy
		assign ring_hit[r] = |(umask[VMEM_NLANE-1:0] & busy[r]);
	end

	////////////////////////////////////////////////////////////////////////
	// Per-class qualify: a masked-off class adds nothing
	for (genvar i = 0; i < VMEM_NMAIN; i++) begin : g_main
		assign fill_main_sel[i] = umask[i] ?
			VMEM_CNTW'(fill_main[i*VMEM_FILLW +: VMEM_FILLW]) : '0;
	end

	for (genvar i = 0; i < 2; i++) begin : g_cred
		assign fill_cred_sel[i] = umask[i] ?
			VMEM_CNTW'(fill_credit[i*VMEM_FILLW +: VMEM_FILLW]) : '0;
	end

	// Worst case is seven full buffers, far below the counter width
	always_comb begin
		fill_main_sum = '0;
		for (int i = 0; i < VMEM_NMAIN; i++) begin
			fill_main_sum = fill_main_sum + fill_main_sel[i];
		end
		fill_cred_sum = fill_cred_sel[0] + fill_cred_sel[1];
	end

	// Several starving classes still make one event per cycle
	assign starve_main_hit = |(umask[VMEM_NMAIN-1:0] & starve_main);
	assign starve_cred_hit = |(umask[VMEM_NCRED-1:0] & starve_credit);

	////////////////////////////////////////////////////////////////////////
	// Event select and increment
	always_comb begin
		inc  = '0;
		kind = vmem_kind_none;
		case (evsel)
			VMEM_EV_OCC_MAIN: begin
				kind = vmem_kind_fill;
				inc  = fill_main_sum;
			end
			VMEM_EV_OCC_CRED: begin
				kind = vmem_kind_fill;
				inc  = fill_cred_sum;
			end
			VMEM_EV_STV_MAIN: begin
				kind = vmem_kind_pulse;
				inc  = VMEM_CNTW'(starve_main_hit);
			end
			VMEM_EV_STV_CRED: begin
				kind = vmem_kind_pulse;
				inc  = VMEM_CNTW'(starve_cred_hit);
			end
			VMEM_EV_REQ_BUSY: begin
				kind = vmem_kind_pulse;
				inc  = VMEM_CNTW'(ring_hit[VMEM_RING_REQ]);
			end
			VMEM_EV_ACK_BUSY: begin
				kind = vmem_kind_pulse;
				inc  = VMEM_CNTW'(ring_hit[VMEM_RING_ACK]);
			end
			VMEM_EV_BLK_BUSY: begin
				kind = vmem_kind_pulse;
				inc  = VMEM_CNTW'(ring_hit[VMEM_RING_BLK]);
			end
			VMEM_EV_AKC_BUSY: begin
				kind = vmem_kind_pulse;
				inc  = VMEM_CNTW'(ring_hit[VMEM_RING_AKC]);
			end
			default: begin
				kind = vmem_kind_none;
				inc  = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Counter: software write or reset bit take priority over counting
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			count_q <= '0;
		end else if (clk_en) begin
			if (ctl_wr && wb_sel_i[2] && wb_dat_i[VMEM_RST_BIT]) begin
				count_q <= '0;
			end else if (cnt_wr_lo) begin
				count_q[31:0] <= wb_dat_i;
			end else if (cnt_wr_hi) begin
				count_q[VMEM_CNTW-1:32] <= wb_dat_i[15:0];
			end else if (ctl_q[VMEM_EN_BIT] && kind != vmem_kind_none) begin
				count_q <= count_q + inc;
			end
		end
	end

endmodule : vmem_monitor

// >>> testbench/vmem_chk_monitor.sv
/* Checker for vmem_monitor: bus handshake and counter steps.
   Assumes it is bound to the vmem_monitor ports. */
`timescale 1ns/1ps
module vmem_chk_monitor
	import vmem_pkg::*;
(
	// Clock, reset and bus
	input wire logic                       core_clk,
	input wire logic                       nrst,
	input wire logic                       clk_en,
	input wire logic                       wb_cyc_i,
	input wire logic                       wb_stb_i,
	input wire logic                       wb_we_i,
	input wire logic [7:0]                 wb_adr_i,
	input wire logic [31:0]                wb_dat_o,
	input wire logic                       wb_ack_o,
	// Events and counter
	input wire logic [VMEM_NMAIN*VMEM_FILLW-1:0] fill_main,
	input wire logic [2*VMEM_FILLW-1:0]    fill_credit,
	input wire logic [VMEM_NMAIN-1:0]      starve_main,
	input wire logic [VMEM_NCRED-1:0]      starve_credit,
	input wire vmem_ring_t [VMEM_NRING-1:0] rings,
	input wire logic [VMEM_CNTW-1:0]       count_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic req;
	logic busy;
	logic fl0;
	always_comb begin
		busy = 1'b0;
		for (int r = 0; r < VMEM_NRING; r++)
			busy = busy | (|(rings[r].valid & ~rings[r].sent_here));
		req = wb_cyc_i & wb_stb_i;
		fl0 = fill_main == '0 && fill_credit == '0;
	end
	chk_ack_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o) else $error("ack held");
	chk_ack_answer: assert property (req && !wb_ack_o && clk_en |=> wb_ack_o) else $error("no ack");
	chk_ack_cause: assert property (!req && clk_en |=> !wb_ack_o) else $error("stray ack");
	chk_freeze_hold: assert property (!clk_en |=> $stable(count_q) && $stable(wb_ack_o))
		else $error("state moved while frozen");
	chk_idle_hold: assert property (fl0 && !busy && !req
		&& starve_main == '0 && starve_credit == '0 |=> $stable(count_q))
		else $error("count moved with no event");
	chk_step_bound: assert property (clk_en && !req
		|=> count_q - $past(count_q) <= 48'h1B9) else $error("count step too large");
	chk_single_step: assert property (clk_en && !req && fl0
		|=> count_q - $past(count_q) <= 48'h1) else $error("count step above one");
	chk_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 8'h10 && !wb_ack_o
		&& clk_en |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
endmodule : vmem_chk_monitor
bind vmem_monitor vmem_chk_monitor u_chk (.core_clk, .nrst, .clk_en, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .fill_main, .fill_credit, .starve_main,
	.starve_credit, .rings, .count_q);

// >>> testbench/vmem_monitor_tb.sv
/* Testbench for vmem_monitor: random events per code on both ring sides,
   checked each cycle against a model. Assumes nothing outside. */
`timescale 1ns/1ps
module vmem_monitor_tb import vmem_pkg::*;;
	logic core_clk = 0, nrst = 0, clk_en = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [7:0] wb_adr_i = '0, code, mask;
	logic [31:0] wb_dat_i = '0, wb_dat_o, rd, seed = 32'hDDE8FFD7;
	logic [3:0] stop_index = '0;
	logic [41:0] fill_main = '0;
	logic [11:0] fill_credit = '0;
	logic [6:0] starve_main = '0;
	logic [2:0] starve_credit = '0;
	vmem_ring_t [3:0] rings = '0;
	logic [47:0] count_q, exp_cnt;
	logic [7:0] codes [9] = '{8'h90, 8'h91, 8'h9A, 8'h9B, 8'hB0, 8'hB1, 8'hB2, 8'hB4, 8'h55};
	int n_errors = 0, n_checks = 0, cyc = 0;
	vmem_monitor u_dut (.core_clk, .nrst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .stop_index, .fill_main,
		.fill_credit, .starve_main, .starve_credit, .rings, .count_q);
	always #5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Model increment from the inputs of the current cycle
	function automatic int inc();
		int s;
		vmem_phys_t p;
		logic [3:0] l;
		int ri;
		s = 0;
		ri = code == 8'hB4 ? 3 : code[1:0];
		p = rings[ri].valid & ~rings[ri].sent_here;
		l = stop_index < 4 ? {p.ccw_odd, p.ccw_even, p.cw_odd, p.cw_even}
			: {p.cw_odd, p.cw_even, p.ccw_odd, p.ccw_even};
		case (code)
			8'h90: for (int i = 0; i < 7; i++) s += mask[i] ? fill_main[6*i +: 6] : 0;
			8'h91: for (int i = 0; i < 2; i++) s += mask[i] ? fill_credit[6*i +: 6] : 0;
			8'h9A: s = |(starve_main & mask[6:0]);
			8'h9B: s = |(starve_credit & mask[2:0]);
			8'hB0, 8'hB1, 8'hB2, 8'hB4: s = |(l & mask[3:0]);
			default: s = 0;
		endcase
		return clk_en ? s : 0;
	endfunction : inc
	task automatic chk(input logic [47:0] got, input logic [47:0] want);
		n_checks++;
		if (got !== want) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk);
	endtask : wb
	task automatic drive(input bit on);
		fill_main <= on ? 42'({rnd(), rnd()}) : '0;
		fill_credit <= on ? 12'(rnd()) : '0;
		starve_main <= on ? 7'(rnd()) : '0;
		starve_credit <= on ? 3'(rnd()) : '0;
		rings <= on ? rnd() : '0;
		clk_en <= on ? (rnd() & 32'h7) != 0 : 1'b1;
	endtask : drive
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			conclude();
		end
	end
	initial begin
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		for (int t = 0; t < 18; t++) begin
			code = codes[t % 9];
			mask = 8'(rnd()) | 8'h01;
			stop_index <= t < 9 ? 4'h2 : 4'h6;
			wb(1'b1, 8'h00, {8'h00, 8'hC2, mask, code});
			wb(1'b0, 8'h00, '0);
			chk(rd, {8'h00, 8'hC0, mask, code});
			wb(1'b0, 8'h04, '0);
			chk(rd, '0);
			exp_cnt = {16'(rnd()), 18'h3FFFF, 14'(rnd())};
			wb(1'b1, 8'h04, exp_cnt[31:0]);
			wb(1'b1, 8'h08, {16'h0000, exp_cnt[47:32]});
			for (int k = 0; k < 41; k++) begin
				@(posedge core_clk);
				exp_cnt += 48'(inc());
				drive(k < 40);
				#1 chk(count_q, exp_cnt);
			end
			wb(1'b0, 8'h04, '0);
			chk(rd, exp_cnt[31:0]);
			wb(1'b0, 8'h08, '0);
			chk(rd, exp_cnt[47:32]);
			wb(1'b1, 8'h0C, '1);
			wb(1'b0, 8'h0C, '0);
			chk(rd, {30'h0, stop_index < 4, 1'b1});
			wb(1'b0, 8'h10, '0);
			chk(rd, '0);
			$display("test %0d code %h done", t, code);
		end
		conclude();
	end
endmodule : vmem_monitor_tb
